//--- common/clic_pkg.sv
// Package of constants and types for the closed-loop integral control block
// Functional notes
// - Clear accumulator when error leaves integral zone
// - Host may request accumulator clear anytime
// - Clear accumulator on control mode change
// - Hold accumulator cleared while disabled
// - Clear accumulator on profile slot change
// - Clear accumulator when error below allowable
// - Output signed, -1023 to +1023 units
// - Current mode target is milliamps
// - Feed-forward term is gain times set point
// - Proportional term is gain times error
// - Velocity reported in units per 100 ms
// - Measured current reported as magnitude
// - Force output zero when error below allowable
// - Limit output magnitude to peak output
// - Raise small nonzero output to nominal
package clic_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TARGET_OFS = 8'h04;
  localparam logic [7:0] KF_OFS = 8'h08;
  localparam logic [7:0] KP_OFS = 8'h0c;
  localparam logic [7:0] KI_OFS = 8'h10;
  localparam logic [7:0] KD_OFS = 8'h14;
  localparam logic [7:0] IZONE_OFS = 8'h18;
  localparam logic [7:0] ALLOW_OFS = 8'h1c;
  localparam logic [7:0] PEAK_OFS = 8'h20;
  localparam logic [7:0] NOMINAL_OFS = 8'h24;
  localparam logic [7:0] FEEDBACK_OFS = 8'h28;
  localparam logic [7:0] OUTPUT_OFS = 8'h2c;
  localparam logic [7:0] ERROR_OFS = 8'h30;
  localparam logic [7:0] ACCUM_OFS = 8'h34;
  localparam logic [7:0] VEL_OFS = 8'h38;
  localparam logic [7:0] CURMAG_OFS = 8'h3c;
  localparam logic [7:0] STATUS_OFS = 8'h40;
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_SLOT_BIT = 3;
  localparam int CTRL_CLEAR_BIT = 4;
  // Output range and fixed point of gains (Q10)
  localparam logic signed [15:0] OUT_FULL = 16'sh03ff;
  localparam int GAIN_FRAC = 10;
  // Velocity window of 100 ms at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int VEL_WIN_MS = 100;
  localparam int VEL_WIN_CYC = VEL_WIN_MS * 1000 * CLK_MHZ;
  // Loop update period in cycles
  localparam int LOOP_CYC = 250;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PEAK_RST = 16'h03ff;
  localparam logic [15:0] NOMINAL_RST = 16'h0000;
  localparam logic [15:0] IZONE_RST = 16'h0000;
  localparam logic [15:0] ALLOW_RST = 16'h0000;
  // Control modes
  typedef enum logic [1:0] {
    CLIC_MODE_OFF,
    CLIC_MODE_POSITION,
    CLIC_MODE_VELOCITY,
    CLIC_MODE_CURRENT
  } clic_mode_t;
endpackage

//--- rtl/clic_shaper.sv
// Output shaping: saturation, peak limit, nominal floor and deadband zero
module clic_shaper (
  input wire logic signed [47:0] sum,
  input wire logic [15:0] peak,
  input wire logic [15:0] nominal,
  input wire logic in_band,
  output logic signed [15:0] shaped
);
  logic signed [47:0] lim;
  logic signed [47:0] pk;
  logic signed [47:0] nm;
  logic signed [47:0] mag;
  // Clamp to full scale, then peak, then apply nominal floor
  always_comb begin
    pk = 48'(signed'({1'b0, peak}));
    if (pk > 48'(clic_pkg::OUT_FULL)) begin
      pk = 48'(clic_pkg::OUT_FULL);
    end
    nm = 48'(signed'({1'b0, nominal}));
    if (nm > pk) begin
      nm = pk;
    end
    lim = sum;
    if (lim > pk) begin
      lim = pk;
    end else if (lim < -pk) begin
      lim = -pk;
    end
    mag = (lim < 0) ? -lim : lim;
    if (lim != 0 && mag < nm) begin
      lim = (lim < 0) ? -nm : nm;
    end
    if (in_band) begin
      lim = '0;
    end
    shaped = lim[15:0];
  end
endmodule // clic_shaper

//--- rtl/clic_top.sv
// Closed-loop controller with integral accumulator management and AXI4-Lite registers
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
module clic_top (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic signed [31:0] SENSOR_POS,
  input wire logic signed [15:0] CURRENT_MEAS,
  output logic signed [15:0] MOTOR_OUT
);
  // Registers
  logic [31:0] ctrl_q, ctrl_d;
  logic signed [31:0] target_q, target_d;
  logic [15:0] kf_q, kf_d, kp_q, kp_d, ki_q, ki_d, kd_q, kd_d;
  logic [15:0] izone_q, izone_d, allow_q, allow_d, peak_q, peak_d, nom_q, nom_d;
  logic clr_req_q, clr_req_d;
  // AXI state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d, bresp_q, bresp_d;
  // Loop state
  logic signed [31:0] err_q, err_d, accum_q, accum_d, prev_err_q, prev_err_d;
  logic signed [31:0] vel_q, vel_d, vel_base_q, vel_base_d;
  logic [31:0] vel_cnt_q, vel_cnt_d;
  logic [15:0] loop_cnt_q, loop_cnt_d;
  logic [15:0] curmag_q, curmag_d;
  logic signed [15:0] out_q, out_d;
  logic [1:0] mode_prev_q, mode_prev_d;
  logic slot_prev_q, slot_prev_d;
  logic clr_seen_q, clr_seen_d;
  // Synchronisers for pin inputs
  logic signed [31:0] pos_s1_q, pos_s2_q;
  logic signed [15:0] cur_s1_q, cur_s2_q;
  logic signed [47:0] sum;
  logic signed [15:0] shaped;
  logic in_band, out_izone, tick, wr_fire;
  logic signed [31:0] meas, abs_err;
  clic_pkg::clic_mode_t mode;
  logic enabled, slot;

  assign mode = clic_pkg::clic_mode_t'(ctrl_q[clic_pkg::CTRL_MODE_LSB +: 2]);
  assign enabled = ctrl_q[clic_pkg::CTRL_ENABLE_BIT];
  assign slot = ctrl_q[clic_pkg::CTRL_SLOT_BIT];

  // Two-stage capture of external measurements
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pos_s1_q <= '0;
      pos_s2_q <= '0;
      cur_s1_q <= '0;
      cur_s2_q <= '0;
    end else begin
      pos_s1_q <= SENSOR_POS;
      pos_s2_q <= pos_s1_q;
      cur_s1_q <= CURRENT_MEAS;
      cur_s2_q <= cur_s1_q;
    end
  end

  // AXI4-Lite slave next state and register writes
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    target_d = target_q;
    kf_d = kf_q;
    kp_d = kp_q;
    ki_d = ki_q;
    kd_d = kd_q;
    izone_d = izone_q;
    allow_d = allow_q;
    peak_d = peak_q;
    nom_d = nom_q;
    clr_req_d = clr_req_q;
    if (S_AXI_AWVALID && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d = S_AXI_WDATA;
    end
    wr_fire = aw_have_q && w_have_q && !bvalid_q;
    if (clr_seen_q) begin
      clr_req_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'h0;
      case (awaddr_q)
        clic_pkg::CTRL_OFS: begin
          ctrl_d = {27'h0, 1'b0, wdata_q[3:0]};
          if (wdata_q[clic_pkg::CTRL_CLEAR_BIT]) begin
            clr_req_d = 1'b1;
          end
        end
        clic_pkg::TARGET_OFS: target_d = wdata_q;
        clic_pkg::KF_OFS: kf_d = wdata_q[15:0];
        clic_pkg::KP_OFS: kp_d = wdata_q[15:0];
        clic_pkg::KI_OFS: ki_d = wdata_q[15:0];
        clic_pkg::KD_OFS: kd_d = wdata_q[15:0];
        clic_pkg::IZONE_OFS: izone_d = wdata_q[15:0];
        clic_pkg::ALLOW_OFS: allow_d = wdata_q[15:0];
        clic_pkg::PEAK_OFS: peak_d = wdata_q[15:0];
        clic_pkg::NOMINAL_OFS: nom_d = wdata_q[15:0];
        clic_pkg::FEEDBACK_OFS, clic_pkg::OUTPUT_OFS, clic_pkg::ERROR_OFS, clic_pkg::ACCUM_OFS,
        clic_pkg::VEL_OFS, clic_pkg::CURMAG_OFS, clic_pkg::STATUS_OFS: bresp_d = 2'h0;
        default: bresp_d = 2'h2;
      endcase
    end
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = 2'h0;
      case (S_AXI_ARADDR[7:0])
        clic_pkg::CTRL_OFS: rdata_d = ctrl_q;
        clic_pkg::TARGET_OFS: rdata_d = target_q;
        clic_pkg::KF_OFS: rdata_d = {16'h0, kf_q};
        clic_pkg::KP_OFS: rdata_d = {16'h0, kp_q};
        clic_pkg::KI_OFS: rdata_d = {16'h0, ki_q};
        clic_pkg::KD_OFS: rdata_d = {16'h0, kd_q};
        clic_pkg::IZONE_OFS: rdata_d = {16'h0, izone_q};
        clic_pkg::ALLOW_OFS: rdata_d = {16'h0, allow_q};
        clic_pkg::PEAK_OFS: rdata_d = {16'h0, peak_q};
        clic_pkg::NOMINAL_OFS: rdata_d = {16'h0, nom_q};
        clic_pkg::FEEDBACK_OFS: rdata_d = meas;
        clic_pkg::OUTPUT_OFS: rdata_d = 32'(out_q);
        clic_pkg::ERROR_OFS: rdata_d = err_q;
        clic_pkg::ACCUM_OFS: rdata_d = accum_q;
        clic_pkg::VEL_OFS: rdata_d = vel_q;
        clic_pkg::CURMAG_OFS: rdata_d = {16'h0, curmag_q};
        clic_pkg::STATUS_OFS: rdata_d = {30'h0, in_band, clr_req_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = 2'h2;
        end
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  // Loop arithmetic helpers
  always_comb begin
    case (mode)
      clic_pkg::CLIC_MODE_VELOCITY: meas = vel_q;
      clic_pkg::CLIC_MODE_CURRENT: meas = 32'(cur_s2_q);
      default: meas = pos_s2_q;
    endcase
    abs_err = (err_q < 0) ? -err_q : err_q;
    in_band = abs_err < 32'(allow_q);
    out_izone = (izone_q != 16'h0) && (abs_err > 32'(izone_q));
    tick = loop_cnt_q == 16'(clic_pkg::LOOP_CYC - 1);
    sum = ((48'(signed'({1'b0, kf_q})) * 48'(target_q))
         + (48'(signed'({1'b0, kp_q})) * 48'(err_q))
         + 48'(accum_q)
         + (48'(signed'({1'b0, kd_q})) * 48'(err_q - prev_err_q))) >>> clic_pkg::GAIN_FRAC;
  end

  clic_shaper u_shaper (
    .sum(sum),
    .peak(peak_q),
    .nominal(nom_q),
    .in_band(in_band),
    .shaped(shaped)
  );

  // Loop state next values
  always_comb begin
    loop_cnt_d = tick ? 16'h0 : loop_cnt_q + 16'h1;
    vel_cnt_d = vel_cnt_q + 32'h1;
    vel_d = vel_q;
    vel_base_d = vel_base_q;
    if (vel_cnt_q == 32'(clic_pkg::VEL_WIN_CYC - 1)) begin
      vel_cnt_d = 32'h0;
      vel_d = pos_s2_q - vel_base_q;
      vel_base_d = pos_s2_q;
    end
    curmag_d = (cur_s2_q < 0) ? 16'(-cur_s2_q) : cur_s2_q;
    err_d = target_q - meas;
    prev_err_d = prev_err_q;
    accum_d = accum_q;
    out_d = out_q;
    mode_prev_d = ctrl_q[clic_pkg::CTRL_MODE_LSB +: 2];
    slot_prev_d = slot;
    clr_seen_d = clr_req_q;
    if (tick) begin
      prev_err_d = err_q;
      accum_d = accum_q + 32'((48'(signed'({1'b0, ki_q})) * 48'(err_q)));
      out_d = (enabled && mode != clic_pkg::CLIC_MODE_OFF) ? shaped : 16'sh0000;
    end
    if (out_izone) begin
      accum_d = '0;
    end
    if (clr_req_q) begin
      accum_d = '0;
    end
    if (mode_prev_q != ctrl_q[clic_pkg::CTRL_MODE_LSB +: 2]) begin
      accum_d = '0;
    end
    if (!enabled) begin
      accum_d = '0;
    end
    if (slot_prev_q != slot) begin
      accum_d = '0;
    end
    if (in_band) begin
      accum_d = '0;
    end
  end

  // Register stage
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= clic_pkg::CTRL_RST;
      target_q <= '0;
      kf_q <= '0;
      kp_q <= '0;
      ki_q <= '0;
      kd_q <= '0;
      izone_q <= clic_pkg::IZONE_RST;
      allow_q <= clic_pkg::ALLOW_RST;
      peak_q <= clic_pkg::PEAK_RST;
      nom_q <= clic_pkg::NOMINAL_RST;
      clr_req_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= '0;
      err_q <= '0;
      accum_q <= '0;
      prev_err_q <= '0;
      vel_q <= '0;
      vel_base_q <= '0;
      vel_cnt_q <= '0;
      loop_cnt_q <= '0;
      curmag_q <= '0;
      out_q <= '0;
      mode_prev_q <= '0;
      slot_prev_q <= 1'b0;
      clr_seen_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      target_q <= target_d;
      kf_q <= kf_d;
      kp_q <= kp_d;
      ki_q <= ki_d;
      kd_q <= kd_d;
      izone_q <= izone_d;
      allow_q <= allow_d;
      peak_q <= peak_d;
      nom_q <= nom_d;
      clr_req_q <= clr_req_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      err_q <= err_d;
      accum_q <= accum_d;
      prev_err_q <= prev_err_d;
      vel_q <= vel_d;
      vel_base_q <= vel_base_d;
      vel_cnt_q <= vel_cnt_d;
      loop_cnt_q <= loop_cnt_d;
      curmag_q <= curmag_d;
      out_q <= out_d;
      mode_prev_q <= mode_prev_d;
      slot_prev_q <= slot_prev_d;
      clr_seen_q <= clr_seen_d;
    end
  end

  // Port drivers
  assign S_AXI_AWREADY = !aw_have_q;
  assign S_AXI_WREADY = !w_have_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign MOTOR_OUT = out_q;

  // Checks
  a_disabled_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !enabled |=> accum_q == 0) else $error("accumulator not cleared while disabled");
  a_band_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    in_band |=> accum_q == 0) else $error("accumulator not cleared in band");
  a_izone_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    out_izone |=> accum_q == 0) else $error("accumulator not cleared outside zone");
  a_manual_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    clr_req_q |=> accum_q == 0) else $error("manual clear ignored");
  a_mode_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $changed(ctrl_q[2:1]) |=> accum_q == 0) else $error("mode change kept accumulator");
  a_slot_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $changed(slot) |=> accum_q == 0) else $error("slot change kept accumulator");
  a_out_range: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    out_q <= clic_pkg::OUT_FULL && out_q >= -clic_pkg::OUT_FULL) else $error("output out of range");
  a_band_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    tick && in_band |=> out_q == 0) else $error("output not zero in band");
  a_peak_limit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    tick |=> (out_q < 0 ? -out_q : out_q) <= $signed({1'b0, $past(peak_q)})) else $error("peak exceeded");
  a_curmag_pos: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !curmag_q[15] || cur_s2_q == 16'sh8000) else $error("negative current magnitude");
endmodule // clic_top

//--- tb/clic_host_model.sv
// Robot controller model: AXI4-Lite master that sets modes, gains and set points
module clic_host_model (
  input wire logic clk,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp, output bit to);
    bit ha, hw, hb;
    to = 1'b1;
    resp = 2'h3;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && to; n++) begin
      // Handshakes judged mid-cycle, acted on at the edge that takes them
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) resp = bresp;
      @(posedge clk);
      if (ha) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (hw) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (hb) begin
        bready <= 1'b0;
        to = 1'b0;
      end
    end
  endtask
  // Read: address held until taken, rready until data seen
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp, output bit to);
    bit ha, hr;
    to = 1'b1;
    resp = 2'h3;
    d = '0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && to; n++) begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      if (hr) begin
        d = rdata;
        resp = rresp;
      end
      @(posedge clk);
      if (ha) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (hr) begin
        rready <= 1'b0;
        to = 1'b0;
      end
    end
  endtask
  // Manual accumulator clear: control word with the clear bit set
  task automatic req_clear(input logic [31:0] ctrl, output logic [1:0] resp, output bit to);
    axi_wr({24'h0, clic_pkg::CTRL_OFS}, ctrl | (32'h1 << clic_pkg::CTRL_CLEAR_BIT), resp, to);
  endtask
endmodule // clic_host_model

//--- tb/tb_top.sv
// Self-checking testbench of the closed-loop controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic signed [31:0] sensor_pos = 32'sh0;
  logic signed [15:0] current_meas = 16'sh0;
  logic signed [15:0] motor_out;
  int fails = 0;
  int n_compared = 0;
  // Clock of 4 ns
  always #2 clk = ~clk;
  clic_top u_dut (.SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SENSOR_POS(sensor_pos),
    .CURRENT_MEAS(current_meas), .MOTOR_OUT(motor_out));
  clic_host_model u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // Verdict and end of run
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Word compare
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Motor output compare, after three loop periods, looked at mid-cycle where it is settled
  task automatic out_is(input string name, input logic [15:0] exp);
    repeat (3 * clic_pkg::LOOP_CYC) @(posedge clk);
    @(negedge clk);
    n_compared++;
    if (motor_out !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, motor_out);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    bit to;
    u_host.axi_wr({24'h0, a}, d, r, to);
    if (to) begin
      fails++;
      final_report();
    end
    chk("write response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    bit to;
    u_host.axi_rd({24'h0, a}, d, r, to);
    if (to) begin
      fails++;
      final_report();
    end
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask
  // Sensor pins change just after an edge
  task automatic drive(input logic signed [31:0] pos, input logic signed [15:0] cur);
    @(posedge clk);
    sensor_pos <= pos;
    current_meas <= cur;
  endtask
  task automatic gains(input logic [31:0] kf, kp, ki, tgt, ctrl);
    wr(clic_pkg::KF_OFS, kf);
    wr(clic_pkg::KP_OFS, kp);
    wr(clic_pkg::KI_OFS, ki);
    wr(clic_pkg::TARGET_OFS, tgt);
    wr(clic_pkg::CTRL_OFS, ctrl);
  endtask
  // Let the integral build, then see that it did
  task automatic build();
    logic [31:0] d;
    repeat (3 * clic_pkg::LOOP_CYC) @(posedge clk);
    rd(clic_pkg::ACCUM_OFS, d);
    chk("accum built", 32'h1, {31'h0, |d});
  endtask
  task automatic t_reset();
    logic [31:0] d;
    rchk("ctrl reset", clic_pkg::CTRL_OFS, clic_pkg::CTRL_RST);
    rchk("peak reset", clic_pkg::PEAK_OFS, {16'h0, clic_pkg::PEAK_RST});
    rchk("nominal reset", clic_pkg::NOMINAL_OFS, 32'h0);
    rd(8'h80, d, 2'h2);
    chk("unmapped data", 32'h0, d);
    wr(8'h80, 32'h5, 2'h2);
    out_is("out reset", 16'h0);
    $display("test reset done");
  endtask
  task automatic t_feed();
    gains(32'h400, 32'h0, 32'h0, 32'd500, 32'h7);
    out_is("feed forward", 16'h01f4);
    rchk("output reg", clic_pkg::OUTPUT_OFS, 32'h1f4);
    rchk("error reg", clic_pkg::ERROR_OFS, 32'd500);
    $display("test feed forward done");
  endtask
  task automatic t_prop();
    gains(32'h0, 32'h800, 32'h0, 32'd100, 32'h7);
    out_is("prop pos", 16'h00c8);
    wr(clic_pkg::TARGET_OFS, 32'hffff_ff9c);
    out_is("prop neg", 16'hff38);
    drive(32'sd40, 16'sd0);
    gains(32'h0, 32'h800, 32'h0, 32'd100, 32'h3);
    out_is("prop position", 16'h0078);
    // Velocity mode: no window has closed yet, so the velocity feedback is zero
    wr(clic_pkg::CTRL_OFS, 32'h5);
    out_is("prop velocity", 16'h00c8);
    rchk("velocity reg", clic_pkg::VEL_OFS, 32'h0);
    drive(32'sd0, 16'sd0);
    $display("test proportional done");
  endtask
  task automatic t_shape();
    wr(clic_pkg::PEAK_OFS, 32'd150);
    gains(32'h0, 32'h800, 32'h0, 32'd100, 32'h7);
    out_is("peak fwd", 16'h0096);
    wr(clic_pkg::TARGET_OFS, 32'hffff_ff9c);
    out_is("peak rev", 16'hff6a);
    wr(clic_pkg::PEAK_OFS, 32'd1023);
    wr(clic_pkg::NOMINAL_OFS, 32'd300);
    wr(clic_pkg::TARGET_OFS, 32'd100);
    out_is("nominal floor", 16'h012c);
    wr(clic_pkg::NOMINAL_OFS, 32'd0);
    gains(32'h1000, 32'h0, 32'h0, 32'd1000, 32'h7);
    out_is("sat fwd", 16'h03ff);
    wr(clic_pkg::TARGET_OFS, 32'hffff_fc18);
    out_is("sat rev", 16'hfc01);
    $display("test shaping done");
  endtask
  task automatic t_mag();
    drive(32'sd0, -16'sd300);
    repeat (3 * clic_pkg::LOOP_CYC) @(posedge clk);
    rchk("current mag", clic_pkg::CURMAG_OFS, 32'h12c);
    drive(32'sd0, 16'sd0);
    $display("test current magnitude done");
  endtask
  task automatic t_accum();
    logic [1:0] r;
    bit to;
    gains(32'h0, 32'h0, 32'h400, 32'd100, 32'h7);
    build();
    u_host.req_clear(32'h7, r, to);
    if (to) begin
      fails++;
      final_report();
    end
    chk("clear response", 32'h0, {30'h0, r});
    rchk("manual clear", clic_pkg::ACCUM_OFS, 32'h0);
    build();
    // Integral gain off around each change, so only the clear can zero the sum
    wr(clic_pkg::KI_OFS, 32'h0);
    wr(clic_pkg::CTRL_OFS, 32'h3);
    rchk("mode change", clic_pkg::ACCUM_OFS, 32'h0);
    wr(clic_pkg::KI_OFS, 32'h400);
    build();
    wr(clic_pkg::KI_OFS, 32'h0);
    wr(clic_pkg::CTRL_OFS, 32'hb);
    rchk("slot change", clic_pkg::ACCUM_OFS, 32'h0);
    wr(clic_pkg::KI_OFS, 32'h400);
    build();
    wr(clic_pkg::CTRL_OFS, 32'ha);
    repeat (3 * clic_pkg::LOOP_CYC) @(posedge clk);
    rchk("disabled", clic_pkg::ACCUM_OFS, 32'h0);
    wr(clic_pkg::CTRL_OFS, 32'hb);
    wr(clic_pkg::IZONE_OFS, 32'd50);
    repeat (3 * clic_pkg::LOOP_CYC) @(posedge clk);
    rchk("outside zone", clic_pkg::ACCUM_OFS, 32'h0);
    wr(clic_pkg::IZONE_OFS, 32'd0);
    // Proportional gain on, so only the deadband can hold the output at zero
    wr(clic_pkg::KP_OFS, 32'h400);
    wr(clic_pkg::ALLOW_OFS, 32'd200);
    out_is("in band out", 16'h0);
    rchk("in band accum", clic_pkg::ACCUM_OFS, 32'h0);
    rchk("in band status", clic_pkg::STATUS_OFS, 32'h2);
    $display("test accumulator done");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_feed();
    t_prop();
    t_shape();
    t_mag();
    t_accum();
    final_report();
  end
endmodule // tb_top
